// ### src/spierr_map.vh
`ifndef SPIERR_MAP_VH
`define SPIERR_MAP_VH
// register indices on the plain port (2-bit address)
`define SPIERR_ADDR_DATA 2'h1
`define SPIERR_ADDR_CTRL 2'h2
`define SPIERR_ADDR_CSR 2'h3
// control register fields
`define SPIERR_CTRL_IE 7
`define SPIERR_CTRL_POE 6
`define SPIERR_CTRL_DIV2 5
`define SPIERR_CTRL_MASTER_SELECT_BIT 4
`define SPIERR_CTRL_CPOL 3
`define SPIERR_CTRL_CPHA 2
// status register fields
`define SPIERR_CSR_DONE 7
`define SPIERR_CSR_WRITE_COLLISION_FLAG 6
`define SPIERR_CSR_OVR 5
`define SPIERR_CSR_MODE_FAULT_FLAG 4
`define SPIERR_CSR_SOD 2
`define SPIERR_CSR_SSM 1
`define SPIERR_CSR_SSI 0
// reset values
`define SPIERR_CTRL_RESET 8'h00
`define SPIERR_CSR_RESET 8'h00
`define SPIERR_BITS_PER_BYTE 4'h8
`endif

// ### src/spierr_core.v
// What this block does
// - master with select low sets mode fault
// - mode fault clears port output enable
// - mode fault clears master select bit
// - fault clears: status read then control write
// - no enable/master set while fault pending
// - fault never set while slave
// - byte while done set sets overrun
// - buffer keeps first byte after clear
// - status read clears overrun
// - data write during transfer discarded, collision
// - collision flag never raises interrupt
// - received byte copied into read buffer
// - halt freezes registers, port inactive
// - slave done in halt wakes device
// - halt wake only if select is low while halted (even if low before entry), as slave
// - shared request gated by enable, cpu mask
// - control bit 7 is interrupt enable
// - control bit 6 port enable, reset cleared
// - done clears: status access then data access
// - software select replaces pin when chosen
`timescale 1ns/100ps
`default_nettype none
`include "spierr_map.vh"
module spierr_core #(
   parameter HALF_DIV = 4
) (
   input wire clk,
   input wire rstn,
   input wire [1:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   input wire cpu_irq_mask,
   input wire halt_mode,
   input wire sck_in,
   input wire mosi_in,
   input wire miso_in,
   input wire ss_n_in,
   output reg sck_out,
   output reg sck_oe,
   output reg mosi_out,
   output reg mosi_oe,
   output reg miso_out,
   output reg miso_oe,
   output reg irq,
   output reg halt_wake
);
   reg [7:0] ctrl_reg, ctrl_next;
   reg [7:0] csr_reg, csr_next;
   reg [7:0] shift_reg, shift_next;
   reg [7:0] rxbuf_reg, rxbuf_next;
   reg [3:0] cnt_reg, cnt_next;
   reg busy_reg, busy_next;
   reg csr_seen_reg, csr_seen_next;
   reg mode_fault_flag_seen_reg, mode_fault_flag_seen_next;
   reg wake_arm_reg;
   reg [7:0] div_reg;
   reg sck_int_reg;
   reg [2:0] sck_s, mosi_s, miso_s, ss_s;
   reg sck_q, mosi_q, miso_q, ss_q;
   reg sck_prev;
   wire ie = ctrl_reg[`SPIERR_CTRL_IE];
   wire poe = ctrl_reg[`SPIERR_CTRL_POE];
   wire master_select_bit = ctrl_reg[`SPIERR_CTRL_MASTER_SELECT_BIT];
   wire cpol = ctrl_reg[`SPIERR_CTRL_CPOL];
   wire cpha = ctrl_reg[`SPIERR_CTRL_CPHA];
   wire done = csr_reg[`SPIERR_CSR_DONE];
   wire mode_fault_flag = csr_reg[`SPIERR_CSR_MODE_FAULT_FLAG];
   wire overrun_flag = csr_reg[`SPIERR_CSR_OVR];
   // three-stage input sync, accept when stages two and three agree
   always @(posedge clk) begin
      if (!rstn) begin
         sck_s <= 3'h0;
         mosi_s <= 3'h0;
         miso_s <= 3'h0;
         ss_s <= 3'h7;
         sck_q <= 1'b0;
         mosi_q <= 1'b0;
         miso_q <= 1'b0;
         ss_q <= 1'b1;
      end else begin
         sck_s <= {sck_s[1:0], sck_in};
         mosi_s <= {mosi_s[1:0], mosi_in};
         miso_s <= {miso_s[1:0], miso_in};
         ss_s <= {ss_s[1:0], ss_n_in};
         if (sck_s[1] == sck_s[2]) sck_q <= sck_s[2];
         if (mosi_s[1] == mosi_s[2]) mosi_q <= mosi_s[2];
         if (miso_s[1] == miso_s[2]) miso_q <= miso_s[2];
         if (ss_s[1] == ss_s[2]) ss_q <= ss_s[2];
      end
   end
   wire ss_int = csr_reg[`SPIERR_CSR_SSM] ? csr_reg[`SPIERR_CSR_SSI] : ss_q;
   // master clock divider: one-cycle toggle enable
   wire div_tick = (div_reg == HALF_DIV[7:0] - 8'h01);
   always @(posedge clk) begin
      if (!rstn || !busy_reg || !master_select_bit) div_reg <= 8'h00;
      else if (div_tick) div_reg <= 8'h00;
      else div_reg <= div_reg + 8'h01;
   end
   // edge events of the active clock, both roles, level relative to cpol
   wire sck_lvl = master_select_bit ? sck_int_reg : (sck_q ^ cpol);
   wire lead = sck_lvl & ~sck_prev;
   wire trail = ~sck_lvl & sck_prev;
   wire sample = cpha ? trail : lead;
   wire shift = cpha ? lead : trail;
   // halt freezes the port, except an armed slave receive
   wire run = poe && (!halt_mode || (!master_select_bit && wake_arm_reg)) && (master_select_bit || !ss_int);
   wire busy_next_ok = busy_reg || (!master_select_bit && !cpha);
   wire sample_ev = run && busy_next_ok && sample;
   wire data_wr = wr && (addr == `SPIERR_ADDR_DATA);
   wire data_rd = rd && (addr == `SPIERR_ADDR_DATA);
   wire ctrl_wr = wr && (addr == `SPIERR_ADDR_CTRL);
   wire csr_rd = rd && (addr == `SPIERR_ADDR_CSR);
   wire csr_wr = wr && (addr == `SPIERR_ADDR_CSR);
   wire byte_end = sample_ev && (cnt_reg == `SPIERR_BITS_PER_BYTE - 4'h1);
   always @* begin
      ctrl_next = ctrl_reg;
      csr_next = csr_reg;
      shift_next = shift_reg;
      rxbuf_next = rxbuf_reg;
      cnt_next = cnt_reg;
      busy_next = busy_reg;
      csr_seen_next = csr_seen_reg;
      mode_fault_flag_seen_next = mode_fault_flag_seen_reg;
      if (csr_rd || csr_wr) csr_seen_next = done;
      if (csr_rd) mode_fault_flag_seen_next = mode_fault_flag;
      if (csr_wr) csr_next[3:0] = {1'b0, wdata[2:0]};
      if (csr_rd) csr_next[`SPIERR_CSR_OVR] = 1'b0;
      if ((data_rd || data_wr) && csr_seen_reg) begin
         csr_next[`SPIERR_CSR_DONE] = 1'b0;
         csr_next[`SPIERR_CSR_WRITE_COLLISION_FLAG] = 1'b0;
         csr_seen_next = 1'b0;
      end
      if (ctrl_wr) begin
         ctrl_next = wdata;
         // refuse enable and master while fault pends
         if (mode_fault_flag && !mode_fault_flag_seen_reg) begin
            ctrl_next[`SPIERR_CTRL_POE] = 1'b0;
            ctrl_next[`SPIERR_CTRL_MASTER_SELECT_BIT] = 1'b0;
         end
         if (mode_fault_flag_seen_reg) csr_next[`SPIERR_CSR_MODE_FAULT_FLAG] = 1'b0;
         mode_fault_flag_seen_next = 1'b0;
      end
      if (data_wr) begin
         if (busy_reg || (!master_select_bit && !ss_int && cpha == 1'b0 && cnt_reg != 4'h0))
            csr_next[`SPIERR_CSR_WRITE_COLLISION_FLAG] = 1'b1;
         else if (!(done && !csr_seen_reg)) begin
            shift_next = wdata;
            if (master_select_bit && poe) busy_next = 1'b1;
         end
      end
      if (sample_ev) begin
         shift_next = {shift_reg[6:0], master_select_bit ? miso_q : mosi_q};
         cnt_next = cnt_reg + 4'h1;
         busy_next = 1'b1;
      end
      if (byte_end) begin
         cnt_next = 4'h0;
         busy_next = 1'b0;
         if (csr_next[`SPIERR_CSR_DONE])
            csr_next[`SPIERR_CSR_OVR] = 1'b1;
         else begin
            rxbuf_next = {shift_reg[6:0], master_select_bit ? miso_q : mosi_q};
            csr_next[`SPIERR_CSR_DONE] = 1'b1;
         end
      end
      if (!master_select_bit && ss_int && !cpha) cnt_next = 4'h0;
      if (master_select_bit && poe && !ss_int) begin
         csr_next[`SPIERR_CSR_MODE_FAULT_FLAG] = 1'b1;
         ctrl_next[`SPIERR_CTRL_POE] = 1'b0;
         ctrl_next[`SPIERR_CTRL_MASTER_SELECT_BIT] = 1'b0;
         busy_next = 1'b0;
         cnt_next = 4'h0;
      end
   end
   always @(posedge clk) begin
      if (!rstn) begin
         ctrl_reg <= `SPIERR_CTRL_RESET;
         csr_reg <= `SPIERR_CSR_RESET;
         shift_reg <= 8'h00;
         rxbuf_reg <= 8'h00;
         cnt_reg <= 4'h0;
         busy_reg <= 1'b0;
         csr_seen_reg <= 1'b0;
         mode_fault_flag_seen_reg <= 1'b0;
         sck_int_reg <= 1'b0;
         sck_prev <= 1'b0;
         wake_arm_reg <= 1'b0;
         rdata <= 8'h00;
         irq <= 1'b0;
         halt_wake <= 1'b0;
         sck_out <= 1'b0;
         sck_oe <= 1'b0;
         mosi_out <= 1'b0;
         mosi_oe <= 1'b0;
         miso_out <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         csr_reg <= csr_next;
         shift_reg <= shift_next;
         rxbuf_reg <= rxbuf_next;
         cnt_reg <= cnt_next;
         busy_reg <= busy_next;
         csr_seen_reg <= csr_seen_next;
         mode_fault_flag_seen_reg <= mode_fault_flag_seen_next;
         sck_prev <= sck_lvl;
         if (!busy_next || !master_select_bit) sck_int_reg <= 1'b0;
         else if (div_tick && !halt_mode) sck_int_reg <= ~sck_int_reg;
         if (shift && run && !master_select_bit) miso_out <= shift_reg[7];
         else if (!busy_reg) miso_out <= shift_next[7];
         if (shift && run && master_select_bit) mosi_out <= shift_reg[7];
         else if (!busy_reg) mosi_out <= shift_next[7];
         rdata <= 8'h00;
         if (rd) begin
            case (addr)
               `SPIERR_ADDR_DATA: rdata <= rxbuf_reg;
               `SPIERR_ADDR_CTRL: rdata <= ctrl_reg;
               `SPIERR_ADDR_CSR: rdata <= csr_reg;
               default: rdata <= 8'h00;
            endcase
         end
         // shared gated request, no collision term
         irq <= ie && !cpu_irq_mask && (done || mode_fault_flag || overrun_flag);
         // arm halt wake at any cycle of halt once select is low as slave
         if (!halt_mode) wake_arm_reg <= 1'b0;
         else if (!halt_wake && !wake_arm_reg) wake_arm_reg <= !ss_int && !master_select_bit;
         halt_wake <= halt_mode && wake_arm_reg && ie && done;
         sck_out <= sck_int_reg ^ cpol;
         sck_oe <= poe && master_select_bit;
         mosi_oe <= poe && master_select_bit && !csr_reg[`SPIERR_CSR_SOD];
         miso_oe <= poe && !master_select_bit && !ss_int && !csr_reg[`SPIERR_CSR_SOD];
      end
   end
endmodule
`default_nettype wire

// ### verif/spierr_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "spierr_map.vh"
module spierr_sva #(
   parameter HALF_DIV = 4
) (
   input wire clk, rstn, wr, rd, cpu_irq_mask, halt_mode, ss_n_in,
   input wire [1:0] addr,
   input wire [7:0] wdata, rdata,
   input wire sck_oe, mosi_oe, miso_oe, irq, halt_wake
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   mask_blocks_irq_a: assert property ($past(cpu_irq_mask) |-> !irq)
      else $error("irq raised while cpu mask set");
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside read slot");
   addr_zero_a: assert property ($past(rd) && $past(addr) == 2'h0 |-> rdata == 8'h00)
      else $error("unmapped read not zero");
   reset_quiet_a: assert property ($past(!rstn) |->
      !irq && !halt_wake && !sck_oe && !mosi_oe && !miso_oe)
      else $error("outputs active after reset");
   fault_drops_a: assert property ((!ss_n_in && !halt_mode && !wr)[*8] |=> !sck_oe)
      else $error("clock still driven with select low");
   ie_off_a: assert property ((wr && addr == `SPIERR_ADDR_CTRL && !wdata[`SPIERR_CTRL_IE])
      ##1 !wr |=> !irq)
      else $error("irq with enable cleared");
   oe_off_a: assert property ((wr && addr == `SPIERR_ADDR_CTRL && !wdata[`SPIERR_CTRL_POE])
      ##1 !wr |=> !sck_oe && !mosi_oe && !miso_oe)
      else $error("pins driven with port disabled");
   lines_excl_a: assert property (!(mosi_oe && miso_oe))
      else $error("both data lines driven");
endmodule
bind spierr_core spierr_sva #(.HALF_DIV(HALF_DIV)) chk_u (.clk(clk), .rstn(rstn), .wr(wr),
   .rd(rd), .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode), .ss_n_in(ss_n_in),
   .addr(addr), .wdata(wdata), .rdata(rdata), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
   .miso_oe(miso_oe), .irq(irq), .halt_wake(halt_wake));
`default_nettype wire

// ### verif/spierr_far.sv
`timescale 1ns/100ps
`default_nettype none
module spierr_far;
   logic sck = 1'b0;
   logic mosi = 1'b1;
   logic ss_n = 1'b1;
   task automatic sel(input logic lvl);
      ss_n = lvl;
   endtask
   task automatic xfer(input logic [7:0] b);
      ss_n = 1'b0;
      #437;
      for (int i = 7; i >= 0; i--) begin
         mosi = b[i];
         #400 sck = 1'b1;
         #400 sck = 1'b0;
      end
      // released line shows the inverse of the last bit
      mosi = ~mosi;
      #400 ss_n = 1'b1;
      #800;
   endtask
endmodule
`default_nettype wire

// ### verif/tb_spierr_core.sv
`timescale 1ns/100ps
`default_nettype none
module tb_spierr_core;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic mask = 1'b0;
   logic halt = 1'b0;
   wire [7:0] rdata;
   wire irq;
   wire sck_oe;
   wire mosi_oe;
   wire miso_oe;
   wire halt_wake;
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [17:0] rows [4] = '{18'h2acac, 18'h3ff07, 18'h30000, 18'h20000};
   spierr_far far_u ();
   spierr_core dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .cpu_irq_mask(mask), .halt_mode(halt), .sck_in(far_u.sck),
      .mosi_in(far_u.mosi), .miso_in(1'b0), .ss_n_in(far_u.ss_n), .sck_out(), .sck_oe(sck_oe),
      .mosi_out(), .mosi_oe(mosi_oe), .miso_out(), .miso_oe(miso_oe), .irq(irq),
      .halt_wake(halt_wake));
   always #50 clk = ~clk;
   task automatic stop_test;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [1:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rchk(2'h2, 8'h00);
      rchk(2'h3, 8'h00);
      rchk(2'h0, 8'h00);
      foreach (rows[i]) begin
         wreg(rows[i][17:16], rows[i][15:8]);
         rchk(rows[i][17:16], rows[i][7:0]);
      end
      // slave with port and interrupt enabled
      wreg(2'h2, 8'hc0);
      far_u.xfer(8'ha5);
      chk({7'h00, irq}, 8'h01);
      mask <= 1'b1;
      repeat (2) @(posedge clk);
      chk({7'h00, irq}, 8'h00);
      mask <= 1'b0;
      rchk(2'h3, 8'h80);
      rchk(2'h1, 8'ha5);
      rchk(2'h3, 8'h00);
      far_u.xfer(8'h3c);
      far_u.xfer(8'h99);
      rchk(2'h3, 8'ha0);
      rchk(2'h1, 8'h3c);
      rchk(2'h3, 8'h00);
      fork
         far_u.xfer(8'h0f);
         begin
            #2500;
            wreg(2'h1, 8'h55);
         end
      join
      rchk(2'h3, 8'hc0);
      rchk(2'h1, 8'h0f);
      rchk(2'h3, 8'h00);
      // slave selected before halt entry, byte received while halted
      far_u.sel(1'b0);
      repeat (6) @(posedge clk);
      chk({7'h00, miso_oe}, 8'h01);
      halt <= 1'b1;
      far_u.xfer(8'h5a);
      chk({7'h00, halt_wake}, 8'h01);
      halt <= 1'b0;
      far_u.xfer(8'h00);
      rchk(2'h3, 8'ha0);
      rchk(2'h1, 8'h5a);
      rchk(2'h3, 8'h00);
      // master, then select pulled low
      wreg(2'h2, 8'h50);
      far_u.sel(1'b0);
      repeat (8) @(posedge clk);
      rchk(2'h2, 8'h00);
      far_u.sel(1'b1);
      repeat (8) @(posedge clk);
      wreg(2'h2, 8'hd0);
      rchk(2'h2, 8'h80);
      chk({7'h00, irq}, 8'h01);
      rchk(2'h3, 8'h10);
      wreg(2'h2, 8'h50);
      rchk(2'h2, 8'h50);
      chk({6'h00, sck_oe, mosi_oe}, 8'h03);
      rchk(2'h3, 8'h00);
      stop_test();
   end
endmodule
`default_nettype wire
